// File: logic/dma_mb_pkg.sv
`default_nettype none
package dma_mb_pkg;
  // ---------------------------------------------------------------
  // Register map (byte offsets)
  // ---------------------------------------------------------------
  localparam int REG_AW = 8;
  localparam logic [7:0] OFF_SRC = 8'h00;
  localparam logic [7:0] OFF_DST = 8'h04;
  localparam logic [7:0] OFF_LLP = 8'h08;
  localparam logic [7:0] OFF_CTL = 8'h0c;
  localparam logic [7:0] OFF_CFG = 8'h10;
  localparam logic [7:0] OFF_CMD = 8'h14;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTL_INT_EN_BIT = 0;
  localparam int CTL_DST_CHAIN_BIT = 27;
  localparam int CTL_SRC_CHAIN_BIT = 28;
  localparam int CFG_BLOCK_MASK_BIT = 0;
  localparam int CFG_SRC_RELOAD_BIT = 30;
  localparam int CFG_DST_RELOAD_BIT = 31;
  localparam int LOC_LSB = 2;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_CLEAR_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_STALL_BIT = 1;
  // ---------------------------------------------------------------
  // Descriptor layout and address steps
  // ---------------------------------------------------------------
  localparam logic [2:0] DESC_WORDS = 3'h4;
  localparam logic [2:0] DESC_LAST = 3'h3;
  localparam logic [31:0] DESC_CTL_OFF = 32'h0000_000c;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {UPD_KEEP, UPD_CONTIG, UPD_RELOAD, UPD_CHAIN} upd_t;
  typedef struct packed {
    upd_t src;
    upd_t dst;
    upd_t ctl;
    logic wb;
    logic stall;
    logic last;
  } plan_t;
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] llp;
    logic [31:0] ctl;
  } desc_t;
  typedef enum {ST_IDLE, ST_FETCH, ST_RUN, ST_WB, ST_NEXT, ST_STALL, ST_ADV} state_t;
endpackage
`default_nettype wire

// File: logic/dma_multiblock_update.sv
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// Descriptor word FIFO
// ---------------------------------------------------------------
module desc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r, rp_r;
  logic [PW:0] cnt_r;
  logic push, pop;
  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// ---------------------------------------------------------------
// Channel multi-block sequencer
// ---------------------------------------------------------------
module dma_multiblock_update #(
  parameter int FIFO_DEPTH = dma_mb_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [dma_mb_pkg::REG_AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [dma_mb_pkg::REG_AW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Descriptor memory master
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Block data engine
  output logic block_start,
  output logic [31:0] blk_src_addr,
  output logic [31:0] blk_dst_addr,
  output logic [31:0] blk_ctrl,
  input wire logic block_done,
  input wire logic [31:0] src_last_addr,
  input wire logic [31:0] dst_last_addr,
  output logic channel_busy
);
  dma_mb_pkg::state_t state_r;
  dma_mb_pkg::plan_t plan_r;
  dma_mb_pkg::desc_t init_r, shadow_r;
  logic [31:0] src_r, dst_r, llp_r, ctl_r, cfg_r, cur_desc_r, last_src_r, last_dst_r;
  logic [2:0] req_cnt_r, pop_cnt_r;
  logic mem_req_r, mem_we_r, block_start_r, busy_r;
  logic [31:0] mem_addr_r, mem_wdata_r;
  logic awready_r, wready_r, arready_r, bvalid_r, rvalid_r, aw_hold_r, w_hold_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, wdata_r;
  logic [3:0] wstrb_r;
  logic [dma_mb_pkg::REG_AW-1:0] awaddr_r;
  logic do_write, start_cmd, clear_cmd, f_in_ready, f_out_valid, f_pop, last_pop;
  logic [31:0] f_out_data;

  // Mode decode, used at start and at every block end
  function automatic dma_mb_pkg::plan_t plan_of(input logic [31:0] ctl, cfg, llp);
    logic cs, cd, rs, rd, loc;
    dma_mb_pkg::plan_t p;
    cs = ctl[dma_mb_pkg::CTL_SRC_CHAIN_BIT];
    cd = ctl[dma_mb_pkg::CTL_DST_CHAIN_BIT];
    rs = cfg[dma_mb_pkg::CFG_SRC_RELOAD_BIT];
    rd = cfg[dma_mb_pkg::CFG_DST_RELOAD_BIT];
    loc = (llp[31:dma_mb_pkg::LOC_LSB] != '0);
    p.last = !cs && !cd && !rs && !rd;
    p.wb = loc;
    p.ctl = (cs || cd) ? dma_mb_pkg::UPD_CHAIN :
            (rs || rd) ? dma_mb_pkg::UPD_RELOAD : dma_mb_pkg::UPD_KEEP;
    // chain, reload or carry per side
    p.src = cs ? dma_mb_pkg::UPD_CHAIN : rs ? dma_mb_pkg::UPD_RELOAD :
            p.last ? dma_mb_pkg::UPD_KEEP : dma_mb_pkg::UPD_CONTIG;
    p.dst = cd ? dma_mb_pkg::UPD_CHAIN : rd ? dma_mb_pkg::UPD_RELOAD :
            p.last ? dma_mb_pkg::UPD_KEEP : dma_mb_pkg::UPD_CONTIG;
    p.stall = (rs || rd) && ctl[dma_mb_pkg::CTL_INT_EN_BIT] &&
              !cfg[dma_mb_pkg::CFG_BLOCK_MASK_BIT];
    return p;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, nw, input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
  assign start_cmd = do_write && (awaddr_r == dma_mb_pkg::OFF_CMD) && wstrb_r[0] &&
                     wdata_r[dma_mb_pkg::CMD_START_BIT] && (state_r == dma_mb_pkg::ST_IDLE);
  assign clear_cmd = do_write && (awaddr_r == dma_mb_pkg::OFF_CMD) && wstrb_r[0] &&
                     wdata_r[dma_mb_pkg::CMD_CLEAR_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= dma_mb_pkg::REG_RESET;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= dma_mb_pkg::AXI_OKAY;
    end else begin
      if (s_awvalid && awready_r) begin
        awaddr_r <= s_awaddr;
        aw_hold_r <= 1'b1;
        awready_r <= 1'b0;
      end else if (!aw_hold_r && !bvalid_r) begin
        awready_r <= 1'b1;
      end
      if (s_wvalid && wready_r) begin
        wdata_r <= s_wdata;
        wstrb_r <= s_wstrb;
        w_hold_r <= 1'b1;
        wready_r <= 1'b0;
      end else if (!w_hold_r && !bvalid_r) begin
        wready_r <= 1'b1;
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (awaddr_r[1:0] == 2'b00 && awaddr_r <= dma_mb_pkg::OFF_CMD) ?
                   dma_mb_pkg::AXI_OKAY : dma_mb_pkg::AXI_SLVERR;
      end else if (bvalid_r && s_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= dma_mb_pkg::REG_RESET;
      rresp_r <= dma_mb_pkg::AXI_OKAY;
    end else begin
      if (s_arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rresp_r <= dma_mb_pkg::AXI_OKAY;
        case (s_araddr)
          dma_mb_pkg::OFF_SRC: rdata_r <= src_r;
          dma_mb_pkg::OFF_DST: rdata_r <= dst_r;
          dma_mb_pkg::OFF_LLP: rdata_r <= llp_r;
          dma_mb_pkg::OFF_CTL: rdata_r <= ctl_r;
          dma_mb_pkg::OFF_CFG: rdata_r <= cfg_r;
          dma_mb_pkg::OFF_CMD: begin
            rdata_r <= dma_mb_pkg::REG_RESET;
            rdata_r[dma_mb_pkg::STAT_BUSY_BIT] <= busy_r;
            rdata_r[dma_mb_pkg::STAT_STALL_BIT] <= (state_r == dma_mb_pkg::ST_STALL);
          end
          default: begin
            rdata_r <= dma_mb_pkg::REG_RESET;
            rresp_r <= dma_mb_pkg::AXI_SLVERR;
          end
        endcase
      end else if (rvalid_r && s_rready) begin
        rvalid_r <= 1'b0;
      end else if (!rvalid_r) begin
        arready_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Descriptor fetch path
  // ---------------------------------------------------------------
  // Drain only while fetching, so words never leak into a running block
  assign f_pop = f_out_valid && (state_r == dma_mb_pkg::ST_FETCH);
  assign last_pop = f_pop && (pop_cnt_r == dma_mb_pkg::DESC_LAST);

  desc_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(mem_req_r && !mem_we_r && mem_ack),
    .in_ready(f_in_ready),
    .in_data(mem_rdata),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      shadow_r <= '0;
    end else if (f_pop) begin
      case (pop_cnt_r)
        3'h0: shadow_r.src <= f_out_data;
        3'h1: shadow_r.dst <= f_out_data;
        3'h2: shadow_r.llp <= f_out_data;
        default: shadow_r.ctl <= f_out_data;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Channel registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      src_r <= dma_mb_pkg::REG_RESET;
      dst_r <= dma_mb_pkg::REG_RESET;
      llp_r <= dma_mb_pkg::REG_RESET;
      ctl_r <= dma_mb_pkg::REG_RESET;
      cfg_r <= dma_mb_pkg::REG_RESET;
      init_r <= '0;
    end else begin
      // Config stays writable mid-transfer so an ISR can drop reload bits
      if (do_write && awaddr_r == dma_mb_pkg::OFF_CFG) begin
        cfg_r <= merge(cfg_r, wdata_r, wstrb_r);
      end
      if (do_write && state_r == dma_mb_pkg::ST_IDLE) begin
        case (awaddr_r)
          dma_mb_pkg::OFF_SRC: src_r <= merge(src_r, wdata_r, wstrb_r);
          dma_mb_pkg::OFF_DST: dst_r <= merge(dst_r, wdata_r, wstrb_r);
          dma_mb_pkg::OFF_LLP: llp_r <= merge(llp_r, wdata_r, wstrb_r);
          dma_mb_pkg::OFF_CTL: ctl_r <= merge(ctl_r, wdata_r, wstrb_r);
          default: ;
        endcase
      end
      if (start_cmd) begin
        init_r <= '{src: src_r, dst: dst_r, llp: llp_r, ctl: ctl_r};
      end
      if (state_r == dma_mb_pkg::ST_ADV) begin
        if (plan_r.src == dma_mb_pkg::UPD_CONTIG) src_r <= last_src_r + dma_mb_pkg::WORD_STEP;
        if (plan_r.dst == dma_mb_pkg::UPD_CONTIG) dst_r <= last_dst_r + dma_mb_pkg::WORD_STEP;
        if (plan_r.src == dma_mb_pkg::UPD_RELOAD) src_r <= init_r.src;
        if (plan_r.dst == dma_mb_pkg::UPD_RELOAD) dst_r <= init_r.dst;
        if (plan_r.ctl == dma_mb_pkg::UPD_RELOAD) begin
          ctl_r <= init_r.ctl;
          llp_r <= init_r.llp;
        end
      end
      // fetched llp and ctl, plus the address of each chained side, applied in one edge
      if (last_pop) begin
        if (plan_r.src == dma_mb_pkg::UPD_CHAIN) src_r <= shadow_r.src;
        if (plan_r.dst == dma_mb_pkg::UPD_CHAIN) dst_r <= shadow_r.dst;
        llp_r <= shadow_r.llp;
        ctl_r <= f_out_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= dma_mb_pkg::ST_IDLE;
      plan_r <= '0;
      busy_r <= 1'b0;
      block_start_r <= 1'b0;
      cur_desc_r <= dma_mb_pkg::REG_RESET;
      last_src_r <= dma_mb_pkg::REG_RESET;
      last_dst_r <= dma_mb_pkg::REG_RESET;
      req_cnt_r <= 3'h0;
      pop_cnt_r <= 3'h0;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= dma_mb_pkg::REG_RESET;
      mem_wdata_r <= dma_mb_pkg::REG_RESET;
    end else begin
      block_start_r <= 1'b0;
      if (mem_req_r && mem_ack) begin
        mem_req_r <= 1'b0;
      end
      case (state_r)
        dma_mb_pkg::ST_IDLE: begin
          if (start_cmd) begin
            busy_r <= 1'b1;
            plan_r <= plan_of(ctl_r, cfg_r, llp_r);
            cur_desc_r <= {llp_r[31:dma_mb_pkg::LOC_LSB], 2'b00};
            if (plan_of(ctl_r, cfg_r, llp_r).ctl == dma_mb_pkg::UPD_CHAIN) begin
              state_r <= dma_mb_pkg::ST_FETCH;
            end else begin
              state_r <= dma_mb_pkg::ST_RUN;
              block_start_r <= 1'b1;
            end
          end
        end
        dma_mb_pkg::ST_FETCH: begin
          // four descriptor words, one read at a time
          if (!mem_req_r && req_cnt_r != dma_mb_pkg::DESC_WORDS && f_in_ready) begin
            mem_req_r <= 1'b1;
            mem_we_r <= 1'b0;
            mem_addr_r <= cur_desc_r + {27'h0, req_cnt_r, 2'b00};
          end
          if (mem_req_r && mem_ack) begin
            req_cnt_r <= req_cnt_r + 3'h1;
          end
          if (f_pop) begin
            pop_cnt_r <= pop_cnt_r + 3'h1;
          end
          if (last_pop) begin
            req_cnt_r <= 3'h0;
            pop_cnt_r <= 3'h0;
            state_r <= dma_mb_pkg::ST_RUN;
            block_start_r <= 1'b1;
          end
        end
        dma_mb_pkg::ST_RUN: begin
          if (block_done) begin
            // sample the mode at block end
            plan_r <= plan_of(ctl_r, cfg_r, llp_r);
            last_src_r <= src_last_addr;
            last_dst_r <= dst_last_addr;
            if (plan_of(ctl_r, cfg_r, llp_r).wb) begin
              state_r <= dma_mb_pkg::ST_WB;
              mem_req_r <= 1'b1;
              mem_we_r <= 1'b1;
              mem_addr_r <= cur_desc_r + dma_mb_pkg::DESC_CTL_OFF;
              mem_wdata_r <= ctl_r;
            end else begin
              state_r <= dma_mb_pkg::ST_NEXT;
            end
          end
        end
        dma_mb_pkg::ST_WB: begin
          if (mem_req_r && mem_ack) begin
            mem_we_r <= 1'b0;
            state_r <= dma_mb_pkg::ST_NEXT;
          end
        end
        dma_mb_pkg::ST_NEXT: begin
          if (plan_r.last) begin
            state_r <= dma_mb_pkg::ST_IDLE;
            busy_r <= 1'b0;
          end else if (plan_r.stall) begin
            state_r <= dma_mb_pkg::ST_STALL;
          end else begin
            state_r <= dma_mb_pkg::ST_ADV;
          end
        end
        dma_mb_pkg::ST_STALL: begin
          if (clear_cmd) begin
            state_r <= dma_mb_pkg::ST_ADV;
          end
        end
        dma_mb_pkg::ST_ADV: begin
          cur_desc_r <= {llp_r[31:dma_mb_pkg::LOC_LSB], 2'b00};
          if (plan_r.ctl == dma_mb_pkg::UPD_CHAIN) begin
            state_r <= dma_mb_pkg::ST_FETCH;
          end else begin
            state_r <= dma_mb_pkg::ST_RUN;
            block_start_r <= 1'b1;
          end
        end
        default: state_r <= dma_mb_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_awready = awready_r;
  assign s_wready = wready_r;
  assign s_bvalid = bvalid_r;
  assign s_bresp = bresp_r;
  assign s_arready = arready_r;
  assign s_rvalid = rvalid_r;
  assign s_rdata = rdata_r;
  assign s_rresp = rresp_r;
  assign mem_req = mem_req_r;
  assign mem_we = mem_we_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
  assign block_start = block_start_r;
  assign blk_src_addr = src_r;
  assign blk_dst_addr = dst_r;
  assign blk_ctrl = ctl_r;
  assign channel_busy = busy_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_NO_FETCH_IN_BLOCK: assert property (@(posedge clk) disable iff (rst)
    state_r == dma_mb_pkg::ST_RUN |-> !mem_req_r || mem_we_r)
    else $error("descriptor read during a running block");
  AST_WB_NEEDS_LOC: assert property (@(posedge clk) disable iff (rst)
    (mem_req_r && mem_we_r) |-> plan_r.wb && mem_addr_r == cur_desc_r + dma_mb_pkg::DESC_CTL_OFF)
    else $error("write-back without location or to wrong word");
  AST_NO_WB_ZERO_LOC: assert property (@(posedge clk) disable iff (rst)
    (state_r == dma_mb_pkg::ST_RUN && block_done && llp_r[31:dma_mb_pkg::LOC_LSB] == '0)
    |=> state_r == dma_mb_pkg::ST_NEXT ##1 !mem_req_r)
    else $error("write-back with zero location");
  AST_CONTIG_ADDR: assert property (@(posedge clk) disable iff (rst)
    (state_r == dma_mb_pkg::ST_ADV && plan_r.src == dma_mb_pkg::UPD_CONTIG)
    |=> src_r == $past(last_src_r) + dma_mb_pkg::WORD_STEP)
    else $error("contiguous source address wrong");
  AST_RELOAD_DST: assert property (@(posedge clk) disable iff (rst)
    (state_r == dma_mb_pkg::ST_ADV && plan_r.dst == dma_mb_pkg::UPD_RELOAD)
    |=> dst_r == init_r.dst)
    else $error("destination not reloaded");
  AST_CTL_NEVER_CONTIG: assert property (@(posedge clk) disable iff (rst)
    (state_r == dma_mb_pkg::ST_ADV && plan_r.ctl != dma_mb_pkg::UPD_RELOAD)
    |=> ctl_r == $past(ctl_r))
    else $error("control changed outside chain fetch or reload");
  AST_DERIVED_CONTIG: assert property (@(posedge clk) disable iff (rst)
    (state_r == dma_mb_pkg::ST_RUN && block_done && !ctl_r[dma_mb_pkg::CTL_SRC_CHAIN_BIT] &&
     !cfg_r[dma_mb_pkg::CFG_SRC_RELOAD_BIT] && cfg_r[dma_mb_pkg::CFG_DST_RELOAD_BIT])
    |=> plan_r.src == dma_mb_pkg::UPD_CONTIG && plan_r.dst == dma_mb_pkg::UPD_RELOAD)
    else $error("contiguity not derived from mode bits");
  AST_LAST_ENDS: assert property (@(posedge clk) disable iff (rst)
    (state_r == dma_mb_pkg::ST_NEXT && plan_r.last) |=> state_r == dma_mb_pkg::ST_IDLE && !busy_r)
    else $error("final block did not terminate");
  AST_STALL_HOLDS: assert property (@(posedge clk) disable iff (rst)
    (state_r == dma_mb_pkg::ST_STALL && !clear_cmd) |=> state_r == dma_mb_pkg::ST_STALL)
    else $error("stall left without clear");
  AST_FETCH_ADDR: assert property (@(posedge clk) disable iff (rst)
    (mem_req_r && !mem_we_r) |-> (mem_addr_r - cur_desc_r) <= dma_mb_pkg::DESC_CTL_OFF)
    else $error("descriptor read outside item");
endmodule
`default_nettype wire

// File: tb/mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Descriptor memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] m [0:63];
  int dly, n_wr;
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      dly <= 0;
      mem_rdata <= '0;
    end else if (mem_req && !mem_ack) begin
      dly <= dly - 1;
      if (dly == 0) begin
        mem_ack <= 1'b1;
        mem_rdata <= m[mem_addr[7:2]];
        dly <= $urandom_range(2);
        if (mem_we) begin
          m[mem_addr[7:2]] <= mem_wdata;
          n_wr <= n_wr + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/dma_multiblock_update_test.sv
`timescale 1ns/10ps
`default_nettype none
module dma_multiblock_update_test;
  logic clk, rst, s_awvalid, s_wvalid, s_bvalid, s_bready, s_arvalid, s_rvalid, s_rready;
  logic s_awready, s_wready, s_arready, mem_req, mem_we, mem_ack, block_start, block_done;
  logic channel_busy;
  logic [7:0] s_awaddr, s_araddr;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_wdata, s_rdata, mem_addr, mem_wdata, mem_rdata, blk_src_addr, blk_dst_addr;
  logic [31:0] blk_ctrl, src_last_addr, dst_last_addr, f, ls, ld;
  logic [95:0] e;
  logic [95:0] exp_q[$];
  int fails, n_tests, nb, cyc;
  dma_multiblock_update DUT (
    .clk(clk), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .block_start(block_start), .blk_src_addr(blk_src_addr), .blk_dst_addr(blk_dst_addr),
    .blk_ctrl(blk_ctrl), .block_done(block_done), .src_last_addr(src_last_addr),
    .dst_last_addr(dst_last_addr), .channel_busy(channel_busy)
  );
  mem_model ram (
    .clk(clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = dma_mb_pkg::AXI_OKAY);
    // One edge apart, so bready never toggles twice in one step
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    {s_awvalid, s_wvalid, s_bready} <= 3'b111;
    do begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    s_bready <= 1'b0;
    chk(s_bresp, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [1:0] r = dma_mb_pkg::AXI_OKAY);
    @(posedge clk);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'b11;
    do begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    s_rready <= 1'b0;
    chk(s_rdata, x);
    chk(s_rresp, r);
  endtask
  task automatic go(input logic [31:0] s, d, l, c, g);
    wr(dma_mb_pkg::OFF_SRC, s);
    wr(dma_mb_pkg::OFF_DST, d);
    wr(dma_mb_pkg::OFF_LLP, l);
    wr(dma_mb_pkg::OFF_CTL, c);
    wr(dma_mb_pkg::OFF_CFG, g);
    nb = 0;
    wr(dma_mb_pkg::OFF_CMD, 32'h0000_0001);
  endtask
  // Block engine: answers the n-th block start with its last addresses
  task automatic blk(input int n, input logic [31:0] a, b);
    while (nb < n) @(posedge clk);
    repeat (3) @(posedge clk);
    {src_last_addr, dst_last_addr, block_done} <= {a, b, 1'b1};
    @(posedge clk);
    block_done <= 1'b0;
  endtask
  // Write-back adds up to two memory wait cycles before the end
  task automatic fin(input int k, input int w);
    repeat (w) @(posedge clk);
    chk(channel_busy, '0);
    $display("test %0d done", k);
  endtask
  // Watcher: each block start must match the oldest note
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      summarize();
    end
    if (block_start) begin
      nb++;
      e = exp_q.pop_front();
      chk(blk_src_addr, e[95:64]);
      chk(blk_dst_addr, e[63:32]);
      chk(blk_ctrl, e[31:0]);
    end
  end
  initial begin
    {rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, block_done} = 7'b100_0000;
    {s_awaddr, s_araddr, s_wdata, src_last_addr, dst_last_addr} = '0;
    s_wstrb = 4'hf;
    void'($urandom(32'hdf8e_2e77));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wr(8'h18, '0, dma_mb_pkg::AXI_SLVERR);
    rd(8'h18, '0, dma_mb_pkg::AXI_SLVERR);
    exp_q.push_back({32'h0000_0100, 32'h0000_0200, 32'h0000_0000});
    go(32'h0000_0100, 32'h0000_0200, '0, '0, '0);
    blk(1, 32'h0000_01fc, 32'h0000_02fc);
    fin(1, 4);
    chk(ram.n_wr, '0);
    // at least one side always reloads here
    for (int k = 2; k <= 4; k++) begin
      f = {k != 3, k != 2, 30'h0};
      ls = $urandom & 32'h0000_fffc;
      ld = $urandom & 32'h0000_fffc;
      exp_q.push_back({32'h0000_1000, 32'h0000_2000, 32'h0000_0001});
      // reload or carry on per side
      exp_q.push_back({f[30] ? 32'h0000_1000 : ls + 4, f[31] ? 32'h0000_2000 : ld + 4,
                       32'h0000_0001});
      go(32'h0000_1000, 32'h0000_2000, '0, 32'h0000_0001, f);
      blk(1, ls, ld);
      repeat (4) @(posedge clk);
      rd(dma_mb_pkg::OFF_CMD, 32'h0000_0003);
      chk(nb, 1);
      wr(dma_mb_pkg::OFF_CFG, '0);
      wr(dma_mb_pkg::OFF_CMD, 32'h0000_0002);
      blk(2, ls, ld);
      fin(k, 4);
      chk(ram.n_wr, '0);
    end
    {ram.m[16], ram.m[17], ram.m[18], ram.m[19], ram.m[32], ram.m[33], ram.m[34], ram.m[35]} =
      {32'h0000_5000, 32'h0000_6000, 32'h0000_0080, 32'h1000_0000, 32'h0000_50fc,
       32'h0000_8000, 32'h0000_0040, 32'h0000_0000};
    exp_q.push_back({32'h0000_5000, 32'h0000_6000, 32'h1000_0000});
    // chained source resumes at previous end
    exp_q.push_back({32'h0000_50fc, 32'h0000_6104, 32'h0000_0000});
    // pointer to first item, both chain enables set
    go('0, '0, 32'h0000_0040, 32'h1800_0000, '0);
    blk(1, 32'h0000_50fc, 32'h0000_6100);
    blk(2, 32'h0000_70fc, 32'h0000_8100);
    fin(5, 6);
    chk(ram.n_wr, 2);
    summarize();
  end
endmodule
`default_nettype wire
